// File: slsl_light_class.sv
// Ambient light level classifier against standby and active thresholds
`timescale 1ns/10ps
`default_nettype none
module slsl_light_class
  import slsl_pkg::*;
(
  // Measurement and thresholds
  input  wire logic [15:0] lux,
  input  wire logic [15:0] standby_thr,
  input  wire logic [15:0] active_thr,
  // Previous and new classification
  input  wire logic [1:0]  prev_level,
  output logic      [1:0]  next_level
);
  // Equality with a threshold keeps the old state, a small hysteresis
  always_comb begin
    next_level = prev_level;
    if (lux < standby_thr) begin
      next_level = LVL_STANDBY;
    end else if (lux > active_thr) begin
      next_level = LVL_ACTIVE;
    end else if ((lux > standby_thr) && (lux < active_thr)) begin
      next_level = LVL_LOW;
    end
  end
endmodule : slsl_light_class
`default_nettype wire

// File: slsl_master_model.sv
// Register-port master model standing in for the Modbus function engine
`timescale 1ns/10ps
`default_nettype none
module slsl_master_model (
  // Clock
  input  wire logic        clk,
  // Request side
  output var  logic        reg_wr,
  output var  logic        reg_rd,
  output var  logic        reg_input_space,
  output var  logic [15:0] reg_addr,
  output var  logic [15:0] reg_wdata,
  // Answer side
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_ack,
  input  wire logic        reg_exc
);
  // Idle bus at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_input_space = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
  end

  // One word per access; strobe is a single-cycle pulse per the port contract
  task automatic access(input logic wr, input logic isp, input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic x, output logic ok);
    int i;
    ok = 1'b0;
    q = 16'h0000;
    x = 1'b0;
    @(negedge clk);
    reg_wr = wr;
    reg_rd = !wr;
    reg_input_space = isp;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // Released lines flip so a stale value never passes for a request
    reg_input_space = !isp;
    reg_addr = ~a;
    reg_wdata = ~d;
    // Answer is bounded: a lost ack leaves ok low
    for (i = 0; i < 3 && !ok; i++) begin
      if (reg_ack === 1'b1) begin
        ok = 1'b1;
        q = reg_rdata;
        x = reg_exc;
      end else begin
        @(negedge clk);
      end
    end
  endtask : access
endmodule : slsl_master_model
`default_nettype wire

// File: slsl_pkg.sv
// Shared constants for the status LED and ambient light block
package slsl_pkg;
  // System clock rate
  localparam longint CLK_HZ            = 125_000_000;
  // Warm-up time after power-on, in minutes
  localparam longint WARMUP_MINUTES    = 15;
  localparam longint WARMUP_CYCLES     = WARMUP_MINUTES * 60 * CLK_HZ;
  // Blink half period in milliseconds and one second in cycles
  localparam longint BLINK_HALF_MS     = 500;
  localparam longint BLINK_CYCLES      = (BLINK_HALF_MS * CLK_HZ) / 1000;
  localparam longint SECOND_CYCLES     = CLK_HZ;

  // Holding register offsets
  localparam logic [15:0] ADDR_BUS_SILENCE_TIMEOUT    = 16'h0008;
  localparam logic [15:0] ADDR_TERMINATION_ENABLE     = 16'h0009;
  localparam logic [15:0] ADDR_LIGHT_STANDBY_THRESHOLD = 16'h0023;
  localparam logic [15:0] ADDR_LIGHT_ACTIVE_THRESHOLD = 16'h0024;
  localparam logic [15:0] ADDR_LED_SOURCE_SELECT      = 16'h004f;
  localparam logic [15:0] ADDR_LED_BRIGHTNESS         = 16'h0050;
  // Input register offsets
  localparam logic [15:0] ADDR_AMBIENT_LIGHT_LUX      = 16'h0029;
  localparam logic [15:0] ADDR_LIGHT_LEVEL_STATE      = 16'h002a;

  // Reset values
  localparam logic [15:0] RST_BUS_SILENCE_TIMEOUT     = 16'h0000;
  localparam logic        RST_TERMINATION_ENABLE      = 1'b0;
  localparam logic [15:0] RST_LIGHT_STANDBY_THRESHOLD = 16'h000a;
  localparam logic [15:0] RST_LIGHT_ACTIVE_THRESHOLD  = 16'h0064;
  localparam logic [1:0]  RST_LED_SOURCE_SELECT       = 2'h0;
  localparam logic [6:0]  RST_LED_BRIGHTNESS          = 7'h64;

  // Field positions and limits
  localparam int          TERM_EN_BIT                 = 0;
  localparam logic [6:0]  BRIGHT_MAX                  = 7'h64;
  localparam logic [6:0]  BRIGHT_STEP                 = 7'h0a;
  localparam logic [6:0]  PWM_LAST                    = 7'h63;

  // LED source selection codes
  localparam logic [1:0]  SRC_VOC                     = 2'h0;
  localparam logic [1:0]  SRC_TEMP                    = 2'h1;
  localparam logic [1:0]  SRC_RH                      = 2'h2;

  // Light level state codes
  localparam logic [1:0]  LVL_STANDBY                 = 2'h0;
  localparam logic [1:0]  LVL_LOW                     = 2'h1;
  localparam logic [1:0]  LVL_ACTIVE                  = 2'h2;
endpackage : slsl_pkg

// File: slsl_status.sv
// Status LED driver, warm-up timer and ambient light register block
`timescale 1ns/10ps
`default_nettype none
module slsl_status
  import slsl_pkg::*;
#(
  parameter longint WARMUP_LEN = WARMUP_CYCLES,
  parameter longint BLINK_LEN  = BLINK_CYCLES,
  parameter longint SECOND_LEN = SECOND_CYCLES
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Register access from the Modbus function engine
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic             reg_input_space,
  input  wire logic [15:0]      reg_addr,
  input  wire logic [15:0]      reg_wdata,
  output wire logic [15:0]      reg_rdata,
  output wire logic             reg_ack,
  output wire logic             reg_exc,
  // Bus traffic seen by the frame receiver
  input  wire logic             bus_activity,
  // Measurements: 0 VOC, 1 temperature, 2 humidity
  input  wire logic [2:0][15:0] meas_value,
  input  wire logic [2:0][15:0] alert_min,
  input  wire logic [2:0][15:0] alert_max,
  input  wire logic [2:0][15:0] range_min,
  input  wire logic [2:0][15:0] range_max,
  input  wire logic [15:0]      ambient_lux_in,
  // Device conditions
  input  wire logic             sensor_link_lost,
  input  wire logic             boot_mode,
  input  wire logic             fw_download,
  // Outputs
  output wire logic             led_green,
  output wire logic             led_yellow,
  output wire logic             led_red,
  output wire logic [15:0]      voc_reported,
  output wire logic             line_termination_resistor,
  output wire logic             warmup_busy
);

  // Whole module state in one record
  typedef struct packed {
    logic [15:0] tmo;       // Bus silence timeout, seconds
    logic        term;      // Termination enable
    logic [15:0] stby;      // Standby threshold
    logic [15:0] actv;      // Active threshold
    logic [1:0]  src;       // LED source select
    logic [6:0]  bright;    // Brightness percent
    logic [15:0] lux;       // Captured lux value
    logic [1:0]  lvl;       // Light level state
    logic [39:0] warm_cnt;  // Warm-up cycle count
    logic        warm;      // Warm-up in progress
    logic [39:0] blink_cnt; // Blink half period count
    logic        phase;     // Blink phase
    logic [39:0] sec_cnt;   // One second prescaler
    logic [15:0] quiet_s;   // Seconds since last traffic
    logic        silent;    // Silence timeout expired
    logic [6:0]  pwm_cnt;   // Brightness PWM position
    logic        ind_g;     // Unmodulated green
    logic        ind_y;     // Unmodulated yellow
    logic        ind_r;     // Unmodulated red
    logic        led_g;     // Modulated outputs
    logic        led_y;
    logic        led_r;
    logic [15:0] voc_out;   // Reported VOC
    logic [15:0] rdata;     // Read data
    logic        ack;       // Access answered
    logic        exc;       // Unmapped access
  } slsl_state_t;

  slsl_state_t s;           // Current state
  slsl_state_t next_s;      // Next state
  logic [1:0]  next_lvl;    // From classifier
  logic [15:0] sel_val;     // Selected quantity
  logic [1:0]  sel_idx;     // Selected index, sanitised
  logic        out_range;   // Outside measurement range
  logic        in_alert;    // Outside alert limits, inside range
  logic        pwm_on;      // Brightness gate
  logic        range_mode;  // No boot, warm-up or fault pattern active

  // Light classifier
  slsl_light_class u_class (
    .lux         (s.lux),
    .standby_thr (s.stby),
    .active_thr  (s.actv),
    .prev_level  (s.lvl),
    .next_level  (next_lvl)
  );

  // Range checks on the chosen quantity; illegal code falls back to VOC
  always_comb begin
    sel_idx   = (s.src == SRC_TEMP || s.src == SRC_RH) ? s.src : SRC_VOC;
    sel_val   = meas_value[sel_idx];
    out_range = (sel_val < range_min[sel_idx]) || (sel_val > range_max[sel_idx]);
    in_alert  = !out_range && ((sel_val < alert_min[sel_idx]) || (sel_val > alert_max[sel_idx]));
    pwm_on    = (s.pwm_cnt < s.bright);
    // Steady colours only show when no blinking pattern claims the LEDs
    range_mode = !boot_mode && !s.warm && !sensor_link_lost && !s.silent;
  end

  // Next state
  always_comb begin
    next_s     = s;
    next_s.ack = 1'b0;
    next_s.exc = 1'b0;
    next_s.lux = ambient_lux_in;
    next_s.lvl = next_lvl;

    // Warm-up timer, runs once after reset
    if (s.warm) begin
      if (s.warm_cnt >= 40'(WARMUP_LEN - 1)) begin
        next_s.warm = 1'b0;
      end else begin
        next_s.warm_cnt = s.warm_cnt + 40'h1;
      end
    end

    // Blink phase generator
    if (s.blink_cnt >= 40'(BLINK_LEN - 1)) begin
      next_s.blink_cnt = '0;
      next_s.phase     = ~s.phase;
    end else begin
      next_s.blink_cnt = s.blink_cnt + 40'h1;
    end

    // Silence seconds; traffic restarts both counters
    if (bus_activity) begin
      next_s.sec_cnt = '0;
      next_s.quiet_s = '0;
    end else if (s.sec_cnt >= 40'(SECOND_LEN - 1)) begin
      next_s.sec_cnt = '0;
      if (s.quiet_s != 16'hffff) begin
        next_s.quiet_s = s.quiet_s + 16'h1;
      end
    end else begin
      next_s.sec_cnt = s.sec_cnt + 40'h1;
    end
    next_s.silent = (s.tmo != 16'h0000) && (s.quiet_s >= s.tmo) && !bus_activity;

    // Brightness PWM, 100 slots
    next_s.pwm_cnt = (s.pwm_cnt >= PWM_LAST) ? 7'h00 : s.pwm_cnt + 7'h01;

    // Indication priority: boot, warm-up, faults, then range
    if (boot_mode) begin
      next_s.ind_g = s.phase;
      next_s.ind_y = ~s.phase;
      next_s.ind_r = fw_download & s.phase;
    end else if (s.warm) begin
      next_s.ind_g = s.phase;
      next_s.ind_y = 1'b0;
      next_s.ind_r = 1'b0;
    end else if (sensor_link_lost || s.silent) begin
      next_s.ind_g = 1'b0;
      next_s.ind_y = s.silent & s.phase;
      next_s.ind_r = sensor_link_lost & s.phase;
    end else begin
      next_s.ind_g = !out_range && !in_alert;
      next_s.ind_y = in_alert;
      next_s.ind_r = out_range;
    end
    next_s.led_g = s.ind_g & pwm_on;
    next_s.led_y = s.ind_y & pwm_on;
    next_s.led_r = s.ind_r & pwm_on;

    // VOC reads zero until warm-up ends
    next_s.voc_out = s.warm ? 16'h0000 : meas_value[SRC_VOC];

    // Register writes, holding space only
    if (reg_wr) begin
      next_s.ack = 1'b1;
      if (reg_input_space) begin
        next_s.exc = 1'b1; // Input registers are read-only
      end else begin
        unique case (reg_addr)
          ADDR_BUS_SILENCE_TIMEOUT:     next_s.tmo  = reg_wdata;
          ADDR_TERMINATION_ENABLE:      next_s.term = reg_wdata[TERM_EN_BIT];
          ADDR_LIGHT_STANDBY_THRESHOLD: next_s.stby = reg_wdata;
          ADDR_LIGHT_ACTIVE_THRESHOLD:  next_s.actv = reg_wdata;
          ADDR_LED_SOURCE_SELECT:       next_s.src  = reg_wdata[1:0];
          ADDR_LED_BRIGHTNESS: begin
            // Clip to 100 and round down to a 10 % step
            if (reg_wdata >= 16'(BRIGHT_MAX)) begin
              next_s.bright = BRIGHT_MAX;
            end else begin
              next_s.bright = reg_wdata[6:0] - (reg_wdata[6:0] % BRIGHT_STEP);
            end
          end
          default:                      next_s.exc  = 1'b1;
        endcase
      end
    end else if (reg_rd) begin
      // Register reads; unmapped answers zero with exception
      next_s.ack   = 1'b1;
      next_s.rdata = 16'h0000;
      if (reg_input_space) begin
        unique case (reg_addr)
          ADDR_AMBIENT_LIGHT_LUX: next_s.rdata = s.lux;
          ADDR_LIGHT_LEVEL_STATE: next_s.rdata = {14'h0000, s.lvl};
          default:                next_s.exc   = 1'b1;
        endcase
      end else begin
        unique case (reg_addr)
          ADDR_BUS_SILENCE_TIMEOUT:     next_s.rdata = s.tmo;
          ADDR_TERMINATION_ENABLE:      next_s.rdata = {15'h0000, s.term};
          ADDR_LIGHT_STANDBY_THRESHOLD: next_s.rdata = s.stby;
          ADDR_LIGHT_ACTIVE_THRESHOLD:  next_s.rdata = s.actv;
          ADDR_LED_SOURCE_SELECT:       next_s.rdata = {14'h0000, s.src};
          ADDR_LED_BRIGHTNESS:          next_s.rdata = {9'h000, s.bright};
          default:                      next_s.exc   = 1'b1;
        endcase
      end
    end
  end

  // State register; warm-up starts at reset release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s        <= '0;
      s.tmo    <= RST_BUS_SILENCE_TIMEOUT;
      s.term   <= RST_TERMINATION_ENABLE;
      s.stby   <= RST_LIGHT_STANDBY_THRESHOLD;
      s.actv   <= RST_LIGHT_ACTIVE_THRESHOLD;
      s.src    <= RST_LED_SOURCE_SELECT;
      s.bright <= RST_LED_BRIGHTNESS;
      s.warm   <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign led_green                 = s.led_g;
  assign led_yellow                = s.led_y;
  assign led_red                   = s.led_r;
  assign voc_reported              = s.voc_out;
  assign line_termination_resistor = s.term;
  assign warmup_busy               = s.warm;
  assign reg_rdata                 = s.rdata;
  assign reg_ack                   = s.ack;
  assign reg_exc                   = s.exc;

  // Checks on the logic above
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_warm_voc_zero: assert property (s.warm |=> voc_reported == 16'h0000)
    else $error("VOC not zero during warm-up");
  chk_boot_no_both: assert property (boot_mode |=> ##1 !(led_green && led_yellow))
    else $error("Green and yellow lit together in bootloader");
  chk_silence_off: assert property (s.tmo == 16'h0000 |=> !s.silent)
    else $error("Silence flagged with zero timeout");
  chk_level_standby: assert property (s.lux < s.stby |=> s.lvl == LVL_STANDBY)
    else $error("Standby level not reported");
  chk_level_active: assert property (s.lux > s.actv && s.lux >= s.stby |=> s.lvl == LVL_ACTIVE)
    else $error("Active level not reported");
  chk_level_low: assert property (s.lux > s.stby && s.lux < s.actv |=> s.lvl == LVL_LOW)
    else $error("Low intensity level not reported");
  chk_term_write: assert property (reg_wr && !reg_input_space && reg_addr == ADDR_TERMINATION_ENABLE
                                   |=> line_termination_resistor == $past(reg_wdata[TERM_EN_BIT]))
    else $error("Termination does not follow its register");
  chk_bright_step: assert property (s.bright <= BRIGHT_MAX && (s.bright % BRIGHT_STEP) == 7'h00)
    else $error("Brightness off the ten-percent grid");
  chk_red_range: assert property (!boot_mode && !s.warm && !sensor_link_lost && !s.silent && out_range
                                  |=> s.ind_r && !s.ind_g && !s.ind_y)
    else $error("Out-of-range not shown as steady red");
  chk_fault_over: assert property (!boot_mode && !s.warm && sensor_link_lost |=> !s.ind_g)
    else $error("Range colour shown over a sensor fault");

  // Warm-up shows a lone blinking green
  chk_warm_green_only: assert property (s.warm && !boot_mode
                                        |=> s.ind_g == $past(s.phase) && !s.ind_y && !s.ind_r)
    else $error("Warm-up pattern is not a lone blinking green");
  // Once warm, the live VOC value is passed one cycle late
  chk_voc_live: assert property (!s.warm |=> voc_reported == $past(meas_value[SRC_VOC]))
    else $error("VOC not reported after warm-up");
  // Inside the alert limits only green is lit
  chk_green_inside: assert property (range_mode && !out_range && !in_alert
                                     |=> s.ind_g && !s.ind_y && !s.ind_r)
    else $error("Value inside alert limits not shown as green");
  // In the alert band only yellow is lit
  chk_yellow_alert: assert property (range_mode && in_alert
                                     |=> s.ind_y && !s.ind_g && !s.ind_r)
    else $error("Alert band not shown as steady yellow");

  // Silence blinks yellow and hides the green range colour
  chk_silence_blink: assert property (!boot_mode && !s.warm && s.silent
                                      |=> s.ind_y == $past(s.phase) && !s.ind_g)
    else $error("Bus silence not shown as blinking yellow");
  // A lost sensor link blinks red
  chk_link_blink: assert property (!boot_mode && !s.warm && sensor_link_lost
                                   |=> s.ind_r == $past(s.phase))
    else $error("Lost sensor link not shown as blinking red");

  // Bootloader: green and yellow in opposite phase
  chk_boot_alternate: assert property (boot_mode
                                       |=> s.ind_g == $past(s.phase) && s.ind_y == !$past(s.phase))
    else $error("Bootloader colours do not alternate");
  // Download adds a red flash, otherwise red stays dark
  chk_download_red: assert property (boot_mode
                                     |=> s.ind_r == ($past(fw_download) && $past(s.phase)))
    else $error("Download red flash wrong in bootloader");
  // Illegal source codes fall back to the VOC value
  chk_source_default: assert property (s.src != SRC_TEMP && s.src != SRC_RH |-> sel_val == meas_value[SRC_VOC])
    else $error("LED source not VOC by default");

  // Dark PWM slot keeps every LED off
  chk_pwm_gate: assert property (!pwm_on |=> !led_green && !led_yellow && !led_red)
    else $error("LED lit in a dark brightness slot");
  // Oversized brightness writes clip to full
  chk_bright_clip: assert property (reg_wr && !reg_input_space && reg_addr == ADDR_LED_BRIGHTNESS
                                    && reg_wdata >= 16'(BRIGHT_MAX) |=> s.bright == BRIGHT_MAX)
    else $error("Brightness above full scale not clipped");

  // Lux is captured every cycle for the read-only register
  chk_lux_capture: assert property (rst_b |=> s.lux == $past(ambient_lux_in))
    else $error("Lux register does not follow the measurement");
  // Writes to the read-only space are answered with an exception
  chk_input_readonly: assert property (reg_wr && reg_input_space |=> reg_ack && reg_exc)
    else $error("Write to input space not refused");
  // Every request is answered one cycle later
  chk_access_ack: assert property (reg_wr || reg_rd |=> reg_ack)
    else $error("Register request not acknowledged");
  // No answer without a request
  chk_no_stray_ack: assert property (!reg_wr && !reg_rd |=> !reg_ack && !reg_exc)
    else $error("Register answer without a request");

endmodule : slsl_status
`default_nettype wire

// File: testbench.sv
// Self-checking testbench for the status LED and light level block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import slsl_pkg::*;
  // Row: source, VOC, temperature, lux, expected green/yellow/red, light level
  typedef struct packed {
    logic [1:0]  src;
    logic [15:0] v0;
    logic [15:0] v1;
    logic [15:0] lux;
    logic [2:0]  gyr;
    logic [1:0]  lvl;
  } slsl_row_t;

  // Clock, reset and stimulus
  logic             clk;
  logic             rst_b;
  logic             bus_activity;
  logic             sensor_link_lost;
  logic             boot_mode;
  logic             fw_download;
  logic [2:0][15:0] meas_value;
  logic [15:0]      ambient_lux_in;
  logic [2:0][15:0] alert_min;
  logic [2:0][15:0] alert_max;
  logic [2:0][15:0] range_min;
  logic [2:0][15:0] range_max;
  // Register port between model and design
  wire logic        reg_wr;
  wire logic        reg_rd;
  wire logic        reg_input_space;
  wire logic [15:0] reg_addr;
  wire logic [15:0] reg_wdata;
  wire logic [15:0] reg_rdata;
  wire logic        reg_ack;
  wire logic        reg_exc;
  // Design outputs
  wire logic        led_green;
  wire logic        led_yellow;
  wire logic        led_red;
  wire logic [15:0] voc_reported;
  wire logic        line_termination_resistor;
  wire logic        warmup_busy;
  // Bookkeeping
  int               errors;
  int               num_checks;
  int               g;
  int               y;
  int               r;
  int               both;
  logic [15:0]      q;
  logic             x;
  slsl_row_t        rows [6];
  logic [31:0]      rst_tab [6];

  // Short counts keep the run small
  slsl_status #(.WARMUP_LEN(200), .BLINK_LEN(4), .SECOND_LEN(10)) i_dut (
    .clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_input_space(reg_input_space),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .reg_exc(reg_exc), .bus_activity(bus_activity), .meas_value(meas_value),
    .alert_min(alert_min), .alert_max(alert_max), .range_min(range_min),
    .range_max(range_max), .ambient_lux_in(ambient_lux_in), .sensor_link_lost(sensor_link_lost),
    .boot_mode(boot_mode), .fw_download(fw_download), .led_green(led_green), .led_yellow(led_yellow),
    .led_red(led_red), .voc_reported(voc_reported), .line_termination_resistor(line_termination_resistor),
    .warmup_busy(warmup_busy));

  // Far-side master
  slsl_master_model i_master (
    .clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_input_space(reg_input_space),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .reg_exc(reg_exc));

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Compare and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  // Register access; a missing answer ends the run
  task automatic acc(input logic wr, input logic isp, input logic [15:0] a, input logic [15:0] d);
    logic ok;
    i_master.access(wr, isp, a, d, q, x, ok);
    if (ok !== 1'b1) begin
      errors++;
      end_sim();
    end
  endtask : acc

  // LED on-counts over n cycles, plus cycles with green and yellow both lit
  task automatic leds(input int n, input int settle);
    int i;
    repeat (settle) @(negedge clk);
    g = 0;
    y = 0;
    r = 0;
    both = 0;
    for (i = 0; i < n; i++) begin
      @(negedge clk);
      g += (led_green === 1'b1);
      y += (led_yellow === 1'b1);
      r += (led_red === 1'b1);
      both += (led_green === 1'b1 && led_yellow === 1'b1);
    end
  endtask : leds

  // Main sequence
  initial begin
    errors = 0;
    num_checks = 0;
    rst_b = 1'b0;
    bus_activity = 1'b0;
    sensor_link_lost = 1'b0;
    boot_mode = 1'b0;
    fw_download = 1'b0;
    meas_value = {16'h0190, 16'h0014, 16'h0096};
    ambient_lux_in = 16'h0005;
    // Temperature alert floor differs so a wrong limit index shows
    alert_min = {16'h0064, 16'h00a0, 16'h0064};
    alert_max = {3{16'h00c8}};
    range_min = {3{16'h0032}};
    range_max = {3{16'h012c}};
    rows = '{'{2'h0, 16'h0096, 16'h0014, 16'h0005, 3'b100, LVL_STANDBY},
             '{2'h0, 16'h0046, 16'h0096, 16'h0032, 3'b010, LVL_LOW},
             '{2'h0, 16'h0014, 16'h0096, 16'h00c8, 3'b001, LVL_ACTIVE},
             '{2'h1, 16'h0014, 16'h0096, 16'h0064, 3'b010, LVL_ACTIVE},
             '{2'h2, 16'h0096, 16'h0096, 16'h000a, 3'b001, LVL_ACTIVE},
             '{2'h3, 16'h0096, 16'h0014, 16'h0009, 3'b100, LVL_STANDBY}};
    rst_tab = '{32'h0008_0000, 32'h0009_0000, 32'h0023_000a, 32'h0024_0064, 32'h004f_0000, 32'h0050_0064};
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    // Warm-up: green blinks alone, VOC reads zero
    leds(40, 4);
    check(g, 20);
    check(y + r, 0);
    check(voc_reported, 16'h0000);
    check(warmup_busy, 1'b1);
    // Reset values of the holding registers
    foreach (rst_tab[k]) begin
      acc(1'b0, 1'b0, rst_tab[k][31:16], 16'h0000);
      check(q, rst_tab[k][15:0]);
    end
    // Bounded wait for the end of warm-up
    for (int k = 0; k < 300 && warmup_busy !== 1'b0; k++) @(negedge clk);
    check(warmup_busy, 1'b0);
    if (warmup_busy !== 1'b0) begin
      end_sim();
    end
    @(negedge clk);
    check(voc_reported, 16'h0096);
    // Range colours, source select and light level per row
    foreach (rows[k]) begin
      acc(1'b1, 1'b0, ADDR_LED_SOURCE_SELECT, {14'h0000, rows[k].src});
      meas_value[0] = rows[k].v0;
      meas_value[1] = rows[k].v1;
      ambient_lux_in = rows[k].lux;
      leds(8, 4);
      check(g, rows[k].gyr[2] ? 8 : 0);
      check(y, rows[k].gyr[1] ? 8 : 0);
      check(r, rows[k].gyr[0] ? 8 : 0);
      acc(1'b0, 1'b1, ADDR_LIGHT_LEVEL_STATE, 16'h0000);
      check(q, {14'h0000, rows[k].lvl});
      acc(1'b0, 1'b1, ADDR_AMBIENT_LIGHT_LUX, 16'h0000);
      check(q, rows[k].lux);
    end
    // Lost sensor link blinks red over a green value
    sensor_link_lost = 1'b1;
    leds(40, 4);
    check(r, 20);
    check(g, 0);
    sensor_link_lost = 1'b0;
    // Bus silence: activity holds it off, then yellow blinks, zero disables
    acc(1'b1, 1'b0, ADDR_BUS_SILENCE_TIMEOUT, 16'h0001);
    bus_activity = 1'b1;
    leds(16, 4);
    check(y, 0);
    bus_activity = 1'b0;
    leds(40, 20);
    check(y, 20);
    acc(1'b1, 1'b0, ADDR_BUS_SILENCE_TIMEOUT, 16'h0000);
    leds(16, 4);
    check(y, 0);
    // Bootloader alternation, then download adds red
    boot_mode = 1'b1;
    leds(40, 4);
    check({g[7:0], y[7:0], both[7:0], r[7:0]}, 32'h1414_0000);
    fw_download = 1'b1;
    leds(40, 4);
    check({g[7:0], y[7:0], both[7:0], r[7:0]}, 32'h1414_0014);
    boot_mode = 1'b0;
    fw_download = 1'b0;
    // Brightness off, rounded down to 30 percent, clipped at full
    acc(1'b1, 1'b0, ADDR_LED_BRIGHTNESS, 16'h0000);
    leds(100, 4);
    check(g, 0);
    acc(1'b1, 1'b0, ADDR_LED_BRIGHTNESS, 16'h0023);
    leds(100, 4);
    check(g, 30);
    acc(1'b1, 1'b0, ADDR_LED_BRIGHTNESS, 16'h00c8);
    leds(100, 4);
    check(g, 100);
    // Line termination follows its register
    acc(1'b1, 1'b0, ADDR_TERMINATION_ENABLE, 16'h0001);
    check(line_termination_resistor, 1'b1);
    check(x, 1'b0);
    acc(1'b0, 1'b0, ADDR_TERMINATION_ENABLE, 16'h0000);
    check(q, 16'h0001);
    // Unmapped read and write to read-only space are refused
    acc(1'b0, 1'b0, 16'h0007, 16'h0000);
    check({x, q}, {1'b1, 16'h0000});
    acc(1'b1, 1'b1, ADDR_AMBIENT_LIGHT_LUX, 16'h1234);
    check(x, 1'b1);
    acc(1'b1, 1'b0, 16'h0007, 16'h00ff);
    check(x, 1'b1);
    // Reset in mid-run clears LED, VOC and termination outputs, raises warm-up busy and restores defaults
    rst_b = 1'b0;
    @(negedge clk);
    check({led_green, led_yellow, led_red, line_termination_resistor, warmup_busy}, 5'b00001);
    check(voc_reported, 16'h0000);
    rst_b = 1'b1;
    acc(1'b0, 1'b0, ADDR_LED_BRIGHTNESS, 16'h0000);
    check(q, 16'h0064);
    check(warmup_busy, 1'b1);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
